// [adc_seq_pkg.sv]
// Shared constants for the conversion sequencer: register map, fields,
// serial command codes, time base and sequencer states.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone slave port.
package adc_seq_pkg;

	// Register byte offsets, word aligned
	localparam int          WB_AW       = 4;
	localparam logic [3:0]  OFS_MODE    = 4'h0;
	localparam logic [3:0]  OFS_RATE    = 4'h4;
	localparam logic [3:0]  OFS_DELAY   = 4'h8;
	localparam logic [3:0]  OFS_STATUS  = 4'hC;

	// Field positions and reset values
	localparam int          MODE_PULSE_BIT = 4;
	localparam int          MODE_AZ_BIT    = 6;
	localparam int          RATE_W         = 5;
	localparam int          FILT_W         = 3;
	localparam int          FILT_LSB       = 8;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [4:0]  RATE_RST       = 5'h04;
	localparam logic [2:0]  FILT_RST       = 3'h5;
	localparam logic [15:0] DELAY_RST_US   = 16'h0032;
	localparam int          ST_BUSY        = 0;
	localparam int          ST_READY       = 1;
	localparam int          ST_CFGERR      = 2;
	localparam int          ST_RUN         = 3;
	localparam int          ST_COUNT_LSB   = 16;

	// Filter codes
	localparam logic [2:0]  FILT_SINC1 = 3'h0;
	localparam logic [2:0]  FILT_SINC2 = 3'h1;
	localparam logic [2:0]  FILT_SINC3 = 3'h2;
	localparam logic [2:0]  FILT_SINC4 = 3'h3;
	localparam logic [2:0]  FILT_SINC5 = 3'h4;
	localparam logic [2:0]  FILT_FIR   = 3'h5;

	// Time base: latencies are counted in tenths of a microsecond
	localparam int          CLK_PERIOD_PS   = 4000;
	localparam int          TENTH_US_PS     = 100000;
	localparam int          TENTH_US_CYCLES = (TENTH_US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          TENTH_W         = 26;
	localparam int          LAT_W           = 24;
	localparam int          TAB_DELAY_US    = 50;
	localparam logic [TENTH_W-1:0] TENTHS_PER_US = 26'h000000A;
	localparam logic [TENTH_W-1:0] TAB_DELAY_TENTHS = TENTH_W'(TAB_DELAY_US * 10);

	// Serial command framing
	localparam int          FRAME_BITS = 32;
	localparam logic [7:0]  CMD_START  = 8'h08;
	localparam logic [7:0]  CMD_STOP   = 8'h0A;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_CONV = 3'b010,
		S_DONE = 3'b100
	} seq_state_t;

endpackage

// [serial_cmd_rx.sv]
// Serial command receiver: counts falling serial-clock edges in a frame
// and issues start or stop pulses. Inputs are already synchronised.
`timescale 1ns/10ps
module serial_cmd_rx
	import adc_seq_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic sclk_s,
	input  wire logic cs_n_s,
	input  wire logic din_s,
	output logic      start_cmd,
	output logic      stop_cmd
);
	logic        sclk_prev_reg, sclk_prev_next;
	logic [5:0]  bits_reg, bits_next;
	logic [30:0] shift_reg, shift_next;
	logic        start_reg, start_next, stop_reg, stop_next;
	logic        fall;
	logic [7:0]  opcode;

	// Shift on falling edges; decode only on the last edge of the frame
	always_comb begin
		fall           = sclk_prev_reg & ~sclk_s;
		opcode         = shift_reg[30:23];
		sclk_prev_next = sclk_s;
		bits_next      = bits_reg;
		shift_next     = shift_reg;
		start_next     = 1'b0;
		stop_next      = 1'b0;
		if (cs_n_s) begin
			bits_next = 6'h00;
		end else if (fall && bits_reg < 6'(FRAME_BITS)) begin
			shift_next = {shift_reg[29:0], din_s};
			bits_next  = bits_reg + 6'h01;
			if (bits_reg == 6'(FRAME_BITS - 1)) begin
				start_next = (opcode == CMD_START);
				stop_next  = (opcode == CMD_STOP);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
			bits_reg      <= 6'h00;
			shift_reg     <= 31'h00000000;
			start_reg     <= 1'b0;
			stop_reg      <= 1'b0;
		end else if (ce) begin
			sclk_prev_reg <= sclk_prev_next;
			bits_reg      <= bits_next;
			shift_reg     <= shift_next;
			start_reg     <= start_next;
			stop_reg      <= stop_next;
		end
	end

	assign start_cmd = start_reg;
	assign stop_cmd  = stop_reg;

	// Nothing may act before the 32nd falling edge
	AST_CMD_NOT_EARLY: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && fall && !cs_n_s && bits_reg < 6'(FRAME_BITS - 1)) |=> (!start_reg && !stop_reg))
		else $error("command applied before last frame edge");
endmodule

// [rate_latency_table.sv]
// Latency table: conversion period in tenths of a microsecond for each
// data rate and filter, registered. Zero marks an unsupported pair.
`timescale 1ns/10ps
module rate_latency_table
	import adc_seq_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic [RATE_W-1:0] rate,
	input  wire logic [FILT_W-1:0] filt,
	output logic [LAT_W-1:0]       period,
	output logic                   valid
);
	logic [4*LAT_W-1:0] row;
	logic [LAT_W-1:0]   fir, s5, lat_next, lat_reg;
	logic               ok_reg;

	// Rows hold sinc4..sinc1; FIR and sinc1 settle in one cycle
	always_comb begin
		row = '0;
		fir = '0;
		s5  = '0;
		case (rate)
			5'd0: begin row = {24'd16000000, 24'd12000000, 24'd8004000, 24'd4004000}; fir = 24'd4022000; end
			5'd1: begin row = {24'd8004000, 24'd6004000, 24'd4004000, 24'd2004000}; fir = 24'd2022000; end
			5'd2: begin row = {24'd4004000, 24'd3004000, 24'd2004000, 24'd1004000}; fir = 24'd1022000; end
			5'd3: row = {24'd2404000, 24'd1804000, 24'd1204000, 24'd604300};
			5'd4: begin row = {24'd2004000, 24'd1504000, 24'd1004000, 24'd504300}; fir = 24'd522200; end
			5'd5: row = {24'd804300, 24'd604300, 24'd404200, 24'd204300};
			5'd6: row = {24'd670900, 24'd504300, 24'd337600, 24'd170900};
			5'd7: row = {24'd404300, 24'd304300, 24'd204200, 24'd104300};
			5'd8: row = {24'd104300, 24'd79250, 24'd54240, 24'd29250};
			5'd9: row = {24'd37580, 24'd29250, 24'd20910, 24'd12580};
			5'd10: row = {24'd20910, 24'd16750, 24'd12580, 24'd8410};
			5'd11: row = {24'd12580, 24'd10500, 24'd8410, 24'd6330};
			5'd12: row = {24'd9800, 24'd8410, 24'd7020, 24'd5640};
			5'd13: s5 = 24'd4230;
			5'd14: s5 = 24'd3360;
			5'd15: s5 = 24'd2710;
			5'd16: s5 = 24'd1790;
			default: row = '0;
		endcase
		case (filt)
			FILT_SINC1: lat_next = row[0*LAT_W +: LAT_W];
			FILT_SINC2: lat_next = row[1*LAT_W +: LAT_W];
			FILT_SINC3: lat_next = row[2*LAT_W +: LAT_W];
			FILT_SINC4: lat_next = row[3*LAT_W +: LAT_W];
			FILT_SINC5: lat_next = s5;
			FILT_FIR:   lat_next = fir;
			default:    lat_next = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lat_reg <= '0;
			ok_reg  <= 1'b0;
		end else if (ce) begin
			lat_reg <= lat_next;
			ok_reg  <= (lat_next != '0);
		end
	end

	assign period = lat_reg;
	assign valid  = ok_reg;

	AST_TAB_FIR20: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && rate == 5'd4 && filt == FILT_FIR) |=> (lat_reg == 24'd522200))
		else $error("FIR 20 SPS period wrong");
endmodule

// [adc_conversion_sequencer.sv]
// Conversion-control sequencer: start pin and serial commands drive a
// timed conversion with a result-ready line; registers over Wishbone.
// Assumes pins are asynchronous to clock and the bus is on clock.
//
// How it works
// - Start pin or serial command controls conversions
// - Command acts at 32nd falling serial edge
// - Mode bit four selects continuous or pulse
// - Continuous mode converts back to back
// - Ready line high at start, low when done
// - Continuous stop lets running conversion finish
// - Fresh start restarts the running conversion
// - Pulse mode does exactly one conversion
// - Pulse mode ignores stop for running conversion
// - FIR and sinc1 settle in one cycle
// - First latency from start to settled data
// - First latency includes programmable start delay
// - Later results follow one data period apart
// - Auto-zero doubles first conversion latency
// - Tabulated latency equals steady conversion period
// - Table assumes no auto-zero, 50 us delay
// - Auto-zero rate is reciprocal of table
// - Start pin high at reset starts converting
`timescale 1ns/10ps
module adc_conversion_sequencer
	import adc_seq_pkg::*;
#(
	parameter int TENTH_CYCLES = adc_seq_pkg::TENTH_US_CYCLES
)
(
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	input  wire logic                          start_pin,
	input  wire logic                          sclk,
	input  wire logic                          cs_n,
	input  wire logic                          din,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [adc_seq_pkg::WB_AW-1:0] wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o,
	output logic                               result_ready_line
);
	import adc_seq_pkg::*;

	localparam int PRESC_W = $clog2(TENTH_CYCLES + 1);

	// Elaboration check: the prescaler needs at least one clock per tenth
	if (TENTH_CYCLES < 1) begin : g_bad_tenth
		$error("TENTH_CYCLES must be at least one");
	end

	// Pin synchronisers: start, serial clock, select, data
	logic [3:0] pins, sync1_reg, sync2_reg;
	logic       start_s, sclk_s, cs_n_s, din_s;

	assign pins = {din, cs_n, sclk, start_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else if (ce) begin
					sync1_reg[gi] <= pins[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign start_s = sync2_reg[0];
	assign sclk_s  = sync2_reg[1];
	assign cs_n_s  = sync2_reg[2];
	assign din_s   = sync2_reg[3];

	// Serial start and stop commands
	logic start_cmd, stop_cmd;

	serial_cmd_rx u_cmd (
		.clock     (clock),
		.rst_n     (rst_n),
		.ce        (ce),
		.sclk_s    (sclk_s),
		.cs_n_s    (cs_n_s),
		.din_s     (din_s),
		.start_cmd (start_cmd),
		.stop_cmd  (stop_cmd)
	);

	// Register file
	logic [7:0]        mode_reg, mode_next;
	logic [RATE_W-1:0] rate_reg, rate_next;
	logic [FILT_W-1:0] filt_reg, filt_next;
	logic [15:0]       delay_reg, delay_next;
	logic [15:0]       count_reg, count_next;
	logic              ack_reg, ack_next;
	logic [31:0]       dat_reg, dat_next;
	logic              wr_en;

	// Sequencer state
	seq_state_t        state_reg, state_next;
	logic [TENTH_W-1:0] remain_reg, remain_next;
	logic [PRESC_W-1:0] presc_reg, presc_next;
	logic              result_ready_line_reg, result_ready_line_next;
	logic              run_reg, run_next;
	logic              start_prev_reg;

	// Derived control
	logic               pulse_mode, az_mode, tick;
	logic               start_event, stop_event;
	logic [LAT_W-1:0]   period_tab;
	logic               cfg_ok;
	logic [TENTH_W-1:0] period_tenths, first_base, first_load;

	rate_latency_table u_tab (
		.clock  (clock),
		.rst_n  (rst_n),
		.ce     (ce),
		.rate   (rate_reg),
		.filt   (filt_reg),
		.period (period_tab),
		.valid  (cfg_ok)
	);

	// Edge of the pin; a pin already high at reset looks like a rise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start_prev_reg <= 1'b0;
		end else if (ce) begin
			start_prev_reg <= start_s;
		end
	end

	// Pin and commands are simply merged; the host keeps them apart
	assign start_event = (start_s & ~start_prev_reg) | start_cmd;
	assign stop_event  = (~start_s & start_prev_reg) | stop_cmd;
	assign pulse_mode  = mode_reg[MODE_PULSE_BIT];
	assign az_mode     = mode_reg[MODE_AZ_BIT];

	// Latency loads: table value is the steady period
	assign period_tenths = TENTH_W'(period_tab);
	// Swap the tabulated 50 us for the programmed delay
	assign first_base = TENTH_W'(period_tenths - TAB_DELAY_TENTHS + TENTH_W'(delay_reg) * TENTHS_PER_US);
	// Auto-zero doubles only the first result
	assign first_load = az_mode ? {first_base[TENTH_W-2:0], 1'b0} : first_base;

	assign tick = (presc_reg == PRESC_W'(TENTH_CYCLES - 1));

	// Conversion sequencer next state
	always_comb begin
		state_next  = state_reg;
		remain_next = remain_reg;
		presc_next  = tick ? '0 : presc_reg + 1'b1;
		result_ready_line_next   = result_ready_line_reg;
		run_next    = run_reg;
		count_next  = count_reg;
		case (state_reg)
			S_IDLE: begin
				if (start_event && cfg_ok) begin
					state_next  = S_CONV;
					remain_next = first_load;
					presc_next  = '0;
					result_ready_line_next   = 1'b1;
					run_next    = 1'b1;
				end
			end
			S_CONV: begin
				if (start_event && cfg_ok) begin
					// Full reload, delay included
					remain_next = first_load;
					presc_next  = '0;
					run_next    = 1'b1;
				end else begin
					if (stop_event && !pulse_mode) begin
						run_next = 1'b0;
					end
					// Stop in pulse mode changes nothing
					if (tick) begin
						if (remain_reg <= TENTH_W'(1)) begin
							state_next = S_DONE;
							result_ready_line_next  = 1'b0;
							count_next = count_reg + 16'h0001;
						end else begin
							remain_next = remain_reg - TENTH_W'(1);
						end
					end
				end
			end
			S_DONE: begin
				presc_next = '0;
				if (start_event && cfg_ok) begin
					state_next  = S_CONV;
					remain_next = first_load;
					result_ready_line_next   = 1'b1;
					run_next    = 1'b1;
				end else if (!pulse_mode && run_reg && !stop_event) begin
					// Back to back at one data period
					state_next  = S_CONV;
					remain_next = period_tenths;
					result_ready_line_next   = 1'b1;
				end else begin
					state_next = S_IDLE;
					run_next   = 1'b0;
				end
			end
			default: begin
				state_next = S_IDLE;
				result_ready_line_next  = 1'b0;
				run_next   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= S_IDLE;
			remain_reg <= '0;
			presc_reg  <= '0;
			result_ready_line_reg   <= 1'b0;
			run_reg    <= 1'b0;
			count_reg  <= 16'h0000;
		end else if (ce) begin
			state_reg  <= state_next;
			remain_reg <= remain_next;
			presc_reg  <= presc_next;
			result_ready_line_reg   <= result_ready_line_next;
			run_reg    <= run_next;
			count_reg  <= count_next;
		end
	end

	assign result_ready_line = result_ready_line_reg;

	// Bus slave: ack one cycle after the request, write on the ack edge
	always_comb begin
		ack_next   = wb_cyc_i & wb_stb_i & ~ack_reg;
		wr_en      = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
		mode_next  = mode_reg;
		rate_next  = rate_reg;
		filt_next  = filt_reg;
		delay_next = delay_reg;
		dat_next   = dat_reg;
		if (wr_en) begin
			case (wb_adr_i)
				OFS_MODE: begin
					if (wb_sel_i[0]) mode_next = wb_dat_i[7:0];
				end
				OFS_RATE: begin
					if (wb_sel_i[0]) rate_next = wb_dat_i[RATE_W-1:0];
					if (wb_sel_i[1]) filt_next = wb_dat_i[FILT_LSB +: FILT_W];
				end
				OFS_DELAY: begin
					if (wb_sel_i[0]) delay_next[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) delay_next[15:8] = wb_dat_i[15:8];
				end
				default: delay_next = delay_reg;
			endcase
		end
		// Read data sampled as ack rises; unmapped reads return zero
		if (ack_next) begin
			dat_next = 32'h00000000;
			case (wb_adr_i)
				OFS_MODE:  dat_next[7:0] = mode_reg;
				OFS_RATE: begin
					dat_next[RATE_W-1:0] = rate_reg;
					dat_next[FILT_LSB +: FILT_W] = filt_reg;
				end
				OFS_DELAY: dat_next[15:0] = delay_reg;
				OFS_STATUS: begin
					dat_next[ST_BUSY]   = (state_reg != S_IDLE);
					dat_next[ST_READY]  = result_ready_line_reg;
					dat_next[ST_CFGERR] = ~cfg_ok;
					dat_next[ST_RUN]    = run_reg;
					dat_next[ST_COUNT_LSB +: 16] = count_reg;
				end
				default: dat_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg   <= 1'b0;
			dat_reg   <= 32'h00000000;
			mode_reg  <= MODE_RST;
			rate_reg  <= RATE_RST;
			filt_reg  <= FILT_RST;
			delay_reg <= DELAY_RST_US;
		end else if (ce) begin
			ack_reg   <= ack_next;
			dat_reg   <= dat_next;
			mode_reg  <= mode_next;
			rate_reg  <= rate_next;
			filt_reg  <= filt_next;
			delay_reg <= delay_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// Checks on the sequencer
	AST_START_READY: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_IDLE && start_event && cfg_ok) |=> (result_ready_line_reg && state_reg == S_CONV))
		else $error("start did not raise ready");

	AST_RESTART_RELOAD: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_CONV && start_event && cfg_ok)
		|=> (remain_reg == $past(first_load) && presc_reg == '0 && state_reg == S_CONV))
		else $error("restart did not reload latency");

	AST_STOP_FINISHES: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_CONV && stop_event && !start_event) |=> (state_reg != S_IDLE))
		else $error("stop aborted running conversion");

	AST_PULSE_ONCE: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_DONE && pulse_mode && !start_event) |=> (state_reg == S_IDLE && !result_ready_line_reg))
		else $error("pulse mode converted again");

	AST_NEXT_PERIOD: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_DONE && !pulse_mode && run_reg && !stop_event && !start_event)
		|=> (state_reg == S_CONV && result_ready_line_reg && remain_reg == $past(period_tenths)))
		else $error("continuous period not loaded");

	AST_READY_LOW_DONE: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == S_DONE) |-> !result_ready_line_reg)
		else $error("ready high when data available");

	AST_AZ_DOUBLE: assert property (@(posedge clock) disable iff (!rst_n)
		az_mode |-> (first_load == TENTH_W'(first_base * 2)))
		else $error("auto-zero first latency not doubled");

	AST_DONE_STEP: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_CONV && tick && remain_reg == TENTH_W'(1) && !start_event)
		|=> (state_reg == S_DONE) ##1 (state_reg != S_DONE || !ce))
		else $error("conversion did not end on last tick");

	AST_WB_ACK: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus request not acknowledged");
endmodule

// [host_link_model.sv]
// Host-side model: drives the start pin and framed serial commands.
// Assumes the bench clock starts a frame; serial clock period is 125 ns.
`timescale 1ns/10ps
module host_link_model (
	input  wire logic clock,
	output logic      start_pin,
	output logic      sclk,
	output logic      cs_n,
	output logic      din
);
	// Idle: select off, serial clock parked low
	initial begin
		start_pin = 1'b0;
		sclk      = 1'b0;
		cs_n      = 1'b1;
		din       = 1'b0;
	end

	task automatic set_pin(input logic v);
		@(posedge clock);
		start_pin <= v;
	endtask

	// Opcode in the first byte, MSB first; returns at the last falling edge
	// Data moves on the rising edge, half a period before it is sampled
	task automatic send_cmd(input logic [7:0] op);
		logic [31:0] w;
		w = {op, 24'h000000};
		@(posedge clock);
		start_pin <= 1'b0;
		cs_n      <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			#62.5;
			sclk <= 1'b1;
			din  <= w[i];
			#62.5;
			sclk <= 1'b0;
		end
	endtask

	// Released data line shows the inverse, so stale bits never pass
	task automatic close_frame();
		repeat (15) @(posedge clock);
		cs_n <= 1'b1;
		din  <= ~din;
	endtask
endmodule

// [testbench.sv]
// Self-checking bench for the conversion sequencer.
// Assumes one tenth of a microsecond is one clock (TENTH_CYCLES = 1).
`timescale 1ns/10ps
module testbench;
	import adc_seq_pkg::*;
	localparam int D  = 2;
	localparam int F5 = 1790 - 500 + 10 * D; // sinc5 40000 SPS, short delay
	localparam int F1 = 5640 - 500 + 10 * D; // sinc1 7200 SPS
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [3:0]  adr   = 4'h0;
	logic [31:0] wdat  = 32'h00000000;
	logic        ce    = 1'b1;
	logic [3:0]  sel   = 4'hF;
	logic [3:0]  wsel  = 4'hF;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        result_ready_line;
	logic        start_pin;
	logic        sclk;
	logic        cs_n;
	logic        din;
	int          num_errors = 0;
	int          n_checks   = 0;

	always #2 clock = ~clock;

	adc_conversion_sequencer #(.TENTH_CYCLES(1)) u_adc_conversion_sequencer (
		.clock(clock), .rst_n(rst_n), .ce(ce), .start_pin(start_pin),
		.sclk(sclk), .cs_n(cs_n), .din(din), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .result_ready_line(result_ready_line));

	host_link_model host (.clock(clock), .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n), .din(din));

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic give_up(input string nm);
		num_errors++;
		$display("mismatch %s expected answer seen timeout", nm);
		tally_and_finish();
	endtask

	// Classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= wsel;
		for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clock);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 20) give_up("wb ack");
	endtask

	task automatic cfg(input logic [31:0] m, input logic [31:0] r);
		wb(1'b1, OFS_MODE, m);
		wb(1'b1, OFS_RATE, r);
		wb(1'b1, OFS_DELAY, 32'(D));
	endtask

	task automatic wait_rdy(input logic v, input int b);
		int i;
		for (i = 0; i < b && result_ready_line !== v; i++) @(posedge clock);
		if (i >= b) give_up("ready level");
	endtask

	// High time of the running conversion, n0 cycles already spent
	task automatic hi(input int n0, input int e, input string nm);
		int n;
		n = n0;
		while (result_ready_line === 1'b1 && n < 12000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 12000)
			give_up(nm);
		else
			chk(32'(n >= e - 3 && n <= e + 3), 32'h00000001, nm);
	endtask

	task automatic stay_low(input int b);
		int n;
		n = 0;
		for (int i = 0; i < b; i++) begin
			@(posedge clock);
			n += int'(result_ready_line !== 1'b0);
		end
		chk(32'(n), 32'h00000000, "no further conversion");
	endtask

	task automatic low_gap();
		int c;
		c = 0;
		while (result_ready_line === 1'b0 && c < 10) begin
			@(posedge clock);
			c++;
		end
		if (c >= 10)
			give_up("gap between results");
		else
			chk(32'(c), 32'h00000001, "gap between results");
	endtask

	task automatic s_regs();
		wb(1'b0, OFS_MODE, 32'h00000000);
		chk(rdat, 32'h00000000, "mode reset");
		wb(1'b0, OFS_RATE, 32'h00000000);
		chk(rdat, 32'h00000504, "rate reset");
		wb(1'b0, OFS_DELAY, 32'h00000000);
		chk(rdat, 32'h00000032, "delay reset");
		// Only byte lane 1 enabled: low delay byte must keep its value
		wsel = 4'h2;
		wb(1'b1, OFS_DELAY, 32'h0000AB77);
		wsel = 4'hF;
		wb(1'b0, OFS_DELAY, 32'h00000000);
		chk(rdat, 32'h0000AB32, "delay byte lane");
		wb(1'b1, 4'h2, 32'hFFFFFFFF);
		wb(1'b0, 4'h2, 32'h00000000);
		chk(rdat, 32'h00000000, "unmapped read");
	endtask

	// Pulse mode: pin dropped mid-run must not cut the conversion short
	task automatic s_pulse();
		cfg(32'h00000010, 32'h00000410);
		host.set_pin(1'b1);
		wait_rdy(1'b1, 12);
		repeat (100) @(posedge clock);
		// Clock enable low for 50 cycles stretches the conversion by 50
		ce <= 1'b0;
		repeat (50) @(posedge clock);
		ce <= 1'b1;
		repeat (150) @(posedge clock);
		host.set_pin(1'b0);
		hi(301, F5 + 50, "pulse length");
		stay_low(2000);
		wb(1'b0, OFS_STATUS, 32'h00000000);
		chk(rdat, 32'h00010000, "status after pulse");
		// Sinc1 at code 13 has no table entry: flagged as unsupported
		wb(1'b1, OFS_RATE, 32'h0000000D);
		wb(1'b0, OFS_STATUS, 32'h00000000);
		chk(rdat, 32'h00010004, "unsupported pair");
	endtask

	// Continuous by command, stopped by command during the second result
	task automatic s_cont();
		cfg(32'h00000000, 32'h00000410);
		host.send_cmd(CMD_START);
		chk(32'(result_ready_line), 32'h00000000, "ready before frame end");
		fork
			host.close_frame();
		join_none
		wait_rdy(1'b1, 12);
		hi(0, F5, "first length");
		low_gap();
		fork
			begin
				host.send_cmd(CMD_STOP);
				host.close_frame();
			end
		join_none
		hi(0, 1790, "next length");
		stay_low(2500);
	endtask

	// Auto-zero: doubled first latency, then table period
	task automatic s_az();
		cfg(32'h00000040, 32'h00000410);
		host.set_pin(1'b1);
		wait_rdy(1'b1, 12);
		hi(0, 2 * F5, "autozero first");
		low_gap();
		host.set_pin(1'b0);
		hi(1, 1790, "autozero next");
		stay_low(2000);
	endtask

	// Toggle low-then-high mid-run restarts with full first latency
	task automatic s_restart();
		cfg(32'h00000000, 32'h0000000C);
		host.set_pin(1'b1);
		wait_rdy(1'b1, 12);
		repeat (500) @(posedge clock);
		host.set_pin(1'b0);
		repeat (6) @(posedge clock);
		host.set_pin(1'b1);
		repeat (10) @(posedge clock);
		host.set_pin(1'b0);
		hi(11, F1 + 4, "restart length");
		stay_low(500);
	endtask

	// Pin already high when reset ends starts converting at once
	task automatic s_rst();
		host.set_pin(1'b1);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		wait_rdy(1'b1, 8);
		chk(32'(result_ready_line), 32'h00000001, "start after reset");
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		s_regs();
		s_pulse();
		s_cont();
		s_az();
		s_restart();
		s_rst();
		tally_and_finish();
	end
endmodule
